// >>> pkg/tcb_pkg.sv
// package: register map, field positions, reset values and mode codes of the timer block
package tcb_pkg;

    // -------------------------------------------------
    // register offsets (data space)
    // -------------------------------------------------
    localparam logic [7:0] TCB_OFF_FLAGS      = 8'h37;
    localparam logic [7:0] TCB_IO_SPACE_DELTA = 8'h20;
    localparam logic [7:0] TCB_OFF_MASK       = 8'h70;
    localparam logic [7:0] TCB_OFF_CTRL_A     = 8'hb0;
    localparam logic [7:0] TCB_OFF_CTRL_B     = 8'hb1;
    localparam logic [7:0] TCB_OFF_COUNT      = 8'hb2;
    localparam logic [7:0] TCB_OFF_CMP_A      = 8'hb3;
    localparam logic [7:0] TCB_OFF_CMP_B      = 8'hb4;

    // -------------------------------------------------
    // field positions
    // -------------------------------------------------
    localparam int TCB_BIT_FORCE_A  = 7;
    localparam int TCB_BIT_FORCE_B  = 6;
    localparam int TCB_BIT_WAVE_HI  = 3;
    localparam int TCB_BIT_CMP_B    = 2;
    localparam int TCB_BIT_CMP_A    = 1;
    localparam int TCB_BIT_OVF      = 0;
    localparam int TCB_BIT_OMODE_A  = 6;
    localparam int TCB_BIT_OMODE_B  = 4;

    // -------------------------------------------------
    // reset values and limits
    // -------------------------------------------------
    localparam logic [7:0] TCB_RESET_VAL = 8'h00;
    localparam logic [7:0] TCB_MAX       = 8'hff;
    localparam logic [7:0] TCB_BOTTOM    = 8'h00;
    localparam logic [7:0] TCB_CTRL_B_RD = 8'h0f;
    localparam logic [7:0] TCB_CTRL_A_RD = 8'hf3;
    localparam logic [7:0] TCB_MASK_RD   = 8'h07;

    // -------------------------------------------------
    // prescaler divisors
    // -------------------------------------------------
    localparam int TCB_DIV_8    = 8;
    localparam int TCB_DIV_32   = 32;
    localparam int TCB_DIV_64   = 64;
    localparam int TCB_DIV_128  = 128;
    localparam int TCB_DIV_256  = 256;
    localparam int TCB_DIV_1024 = 1024;

    // -------------------------------------------------
    // waveform modes (value of the three mode bits)
    // -------------------------------------------------
    localparam logic [2:0] TCB_WM_NORMAL   = 3'h0;
    localparam logic [2:0] TCB_WM_PC_FF    = 3'h1;
    localparam logic [2:0] TCB_WM_CTC      = 3'h2;
    localparam logic [2:0] TCB_WM_FAST_FF  = 3'h3;
    localparam logic [2:0] TCB_WM_PC_OCRA  = 3'h5;
    localparam logic [2:0] TCB_WM_FAST_TOP = 3'h7;

    typedef enum logic [1:0] {
        TCB_OM_OFF,
        TCB_OM_TOGGLE,
        TCB_OM_CLEAR,
        TCB_OM_SET
    } tcb_out_mode_t;

endpackage

// >>> core/tcb_timer.sv
// timer/counter with two compare channels, prescaler and flag/mask registers
// Notes on behaviour
// - writing one to a force bit in non-pwm mode forces that channel's output action.
// - force bits have no effect while any pwm mode is selected.
// - forced compare sets no flag, raises no interrupt, never clears the counter.
// - force bits are strobes, always read back as zero.
// - clock select 0 stops; 1..7 give divide by 1,8,32,64,128,256,1024.
// - counter register is read and written directly by software.
// - a counter write blocks compare matching on the next timer tick.
// - both compare registers are compared continuously; match sets flag, drives output.
// - compare b interrupt requested only when enable, global enable and flag set.
// - compare a interrupt requested only when enable, global enable and flag set.
// - overflow interrupt requested only when enable, global enable and flag set.
// - compare b flag at bit 2 sets on counter match with compare b.
// - compare a flag at bit 1 sets on counter match with compare a.
// - each flag clears when the core executes its interrupt vector.
// - writing one to a flag bit clears it; zero leaves it.
// - flag register answers at data offset and at io offset lower by 0x20.
// - overflow flag sets on overflow, or at bottom turnaround in phase-correct pwm modes.
// - mode-high bit joins two low mode bits to select sequence, top, waveform.
`timescale 1ns/10ps

module tcb_timer
    import tcb_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic [7:0] bus_addr,
    input  wire logic [7:0] bus_wdata,
    input  wire logic       bus_wr,
    input  wire logic       bus_rd,
    output logic      [7:0] bus_rdata,
    input  wire logic       global_irq_en,
    input  wire logic       vec_ack_cmp_a,
    input  wire logic       vec_ack_cmp_b,
    input  wire logic       vec_ack_ovf,
    output logic            irq_cmp_a,
    output logic            irq_cmp_b,
    output logic            irq_ovf,
    output logic            wave_out_a,
    output logic            wave_out_b
);

    // ------------------------------------------------
    // reset release
    // ------------------------------------------------
    logic rst_s1_reg, rst_s2_reg;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end
    logic rst_n_int;
    assign rst_n_int = rst_s2_reg;

    // ------------------------------------------------
    // functions
    // ------------------------------------------------
    function automatic logic wave_next(input logic cur, input logic [1:0] om, input logic up);
        logic r;
        r = cur;
        case (tcb_out_mode_t'(om))
            TCB_OM_OFF:    r = cur;
            TCB_OM_TOGGLE: r = ~cur;
            TCB_OM_CLEAR:  r = ~up;
            TCB_OM_SET:    r = up;
            default:       r = cur;
        endcase
        return r;
    endfunction

    function automatic logic is_pwm(input logic [2:0] wm);
        return wm[0];
    endfunction

    function automatic logic div_tick(input logic [9:0] cnt, input int div);
        logic [9:0] m;
        m = 10'(div - 1);
        return (cnt & m) == m;
    endfunction

    // ------------------------------------------------
    // registers
    // ------------------------------------------------
    logic [7:0] ctrl_a_reg;
    logic       wave_mode_hi_bit_reg;
    logic [2:0] clk_select_reg;
    logic [7:0] count_value_reg;
    logic [7:0] compare_a_value_reg;
    logic [7:0] compare_b_value_reg;
    logic [2:0] irq_mask_reg;
    logic [2:0] irq_flag_reg;
    logic       count_down_reg;
    logic       block_match_reg;
    logic [9:0] presc_reg;
    logic       wave_a_reg, wave_b_reg;

    logic [2:0] wave_mode_sel;
    logic       pwm;
    logic       flag_sel;
    logic       wr_ctrl_b, wr_count;
    assign wave_mode_sel = {wave_mode_hi_bit_reg, ctrl_a_reg[1:0]};
    assign pwm           = is_pwm(wave_mode_sel);
    assign flag_sel      = (bus_addr == TCB_OFF_FLAGS) ||
                           (bus_addr == TCB_OFF_FLAGS - TCB_IO_SPACE_DELTA);
    assign wr_ctrl_b     = bus_wr && (bus_addr == TCB_OFF_CTRL_B);
    assign wr_count      = bus_wr && (bus_addr == TCB_OFF_COUNT);

    // ------------------------------------------------
    // prescaler tick
    // ------------------------------------------------
    logic tick;
    always_comb begin
        case (clk_select_reg)
            3'h0:    tick = 1'b0;
            3'h1:    tick = 1'b1;
            3'h2:    tick = div_tick(presc_reg, TCB_DIV_8);
            3'h3:    tick = div_tick(presc_reg, TCB_DIV_32);
            3'h4:    tick = div_tick(presc_reg, TCB_DIV_64);
            3'h5:    tick = div_tick(presc_reg, TCB_DIV_128);
            3'h6:    tick = div_tick(presc_reg, TCB_DIV_256);
            3'h7:    tick = div_tick(presc_reg, TCB_DIV_1024);
            default: tick = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            presc_reg <= 10'h000;
        end else begin
            presc_reg <= presc_reg + 10'h001;
        end
    end

    // ------------------------------------------------
    // top value and match detection
    // ------------------------------------------------
    logic [7:0] top;
    logic       match_a, match_b, at_top;
    always_comb begin
        case (wave_mode_sel)
            TCB_WM_CTC, TCB_WM_PC_OCRA, TCB_WM_FAST_TOP: top = compare_a_value_reg;
            default:                                     top = TCB_MAX;
        endcase
    end
    assign at_top  = count_value_reg == top;
    assign match_a = tick && !block_match_reg && (count_value_reg == compare_a_value_reg);
    assign match_b = tick && !block_match_reg && (count_value_reg == compare_b_value_reg);

    // ------------------------------------------------
    // counter
    // ------------------------------------------------
    logic pc_mode;
    logic ovf_evt;
    assign pc_mode = (wave_mode_sel == TCB_WM_PC_FF) || (wave_mode_sel == TCB_WM_PC_OCRA);
    always_comb begin
        if (!tick) begin
            ovf_evt = 1'b0;
        end else if (pc_mode) begin
            ovf_evt = count_down_reg && (count_value_reg == TCB_BOTTOM);
        end else if (wave_mode_sel == TCB_WM_FAST_TOP) begin
            ovf_evt = at_top;
        end else begin
            ovf_evt = count_value_reg == TCB_MAX;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            count_value_reg <= TCB_RESET_VAL;
            count_down_reg  <= 1'b0;
        end else if (wr_count) begin
            count_value_reg <= bus_wdata;
        end else if (tick) begin
            if (pc_mode) begin
                if (!count_down_reg && at_top) begin
                    count_down_reg  <= 1'b1;
                    count_value_reg <= count_value_reg - 8'h01;
                end else if (count_down_reg && count_value_reg == TCB_BOTTOM) begin
                    count_down_reg  <= 1'b0;
                    count_value_reg <= count_value_reg + 8'h01;
                end else if (count_down_reg) begin
                    count_value_reg <= count_value_reg - 8'h01;
                end else begin
                    count_value_reg <= count_value_reg + 8'h01;
                end
            end else if (wave_mode_sel != TCB_WM_NORMAL && at_top) begin
                count_value_reg <= TCB_BOTTOM; // reaching top clears, even when matching is blocked; forced compares do not
            end else begin
                count_value_reg <= count_value_reg + 8'h01;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            block_match_reg <= 1'b0;
        end else if (wr_count) begin
            block_match_reg <= 1'b1;
        end else if (tick) begin
            block_match_reg <= 1'b0;
        end
    end

    // ------------------------------------------------
    // control and data registers
    // ------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            ctrl_a_reg           <= TCB_RESET_VAL;
            wave_mode_hi_bit_reg <= 1'b0;
            clk_select_reg       <= 3'h0;
            compare_a_value_reg  <= TCB_RESET_VAL;
            compare_b_value_reg  <= TCB_RESET_VAL;
            irq_mask_reg         <= 3'h0;
        end else if (bus_wr) begin
            case (bus_addr)
                TCB_OFF_CTRL_A: ctrl_a_reg <= bus_wdata & TCB_CTRL_A_RD;
                TCB_OFF_CTRL_B: begin
                    wave_mode_hi_bit_reg <= bus_wdata[TCB_BIT_WAVE_HI];
                    clk_select_reg       <= bus_wdata[2:0];
                end
                TCB_OFF_CMP_A:  compare_a_value_reg <= bus_wdata;
                TCB_OFF_CMP_B:  compare_b_value_reg <= bus_wdata;
                TCB_OFF_MASK:   irq_mask_reg <= bus_wdata[2:0];
                default:        ;
            endcase
        end
    end

    // ------------------------------------------------
    // flags: hardware set wins over clear
    // ------------------------------------------------
    logic [2:0] set_v, clr_v;
    assign set_v = {match_b, match_a, ovf_evt};
    assign clr_v = ((bus_wr && flag_sel) ? bus_wdata[2:0] : 3'h0) |
                   {vec_ack_cmp_b, vec_ack_cmp_a, vec_ack_ovf};
    always_ff @(posedge sys_clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            irq_flag_reg <= 3'h0;
        end else begin
            irq_flag_reg <= (irq_flag_reg & ~clr_v) | set_v;
        end
    end

    assign irq_cmp_b = global_irq_en & irq_mask_reg[TCB_BIT_CMP_B] & irq_flag_reg[TCB_BIT_CMP_B];
    assign irq_cmp_a = global_irq_en & irq_mask_reg[TCB_BIT_CMP_A] & irq_flag_reg[TCB_BIT_CMP_A];
    assign irq_ovf   = global_irq_en & irq_mask_reg[TCB_BIT_OVF] & irq_flag_reg[TCB_BIT_OVF];

    // ------------------------------------------------
    // waveform outputs
    // ------------------------------------------------
    logic force_a, force_b, up_now;
    assign force_a = wr_ctrl_b && bus_wdata[TCB_BIT_FORCE_A] && !pwm;
    assign force_b = wr_ctrl_b && bus_wdata[TCB_BIT_FORCE_B] && !pwm;
    assign up_now  = !pc_mode || !count_down_reg;
    always_ff @(posedge sys_clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            wave_a_reg <= 1'b0;
            wave_b_reg <= 1'b0;
        end else begin
            if (force_a || match_a) begin
                wave_a_reg <= wave_next(wave_a_reg, ctrl_a_reg[TCB_BIT_OMODE_A +: 2], up_now);
            end
            if (force_b || match_b) begin
                wave_b_reg <= wave_next(wave_b_reg, ctrl_a_reg[TCB_BIT_OMODE_B +: 2], up_now);
            end
        end
    end
    assign wave_out_a = wave_a_reg;
    assign wave_out_b = wave_b_reg;

    // ------------------------------------------------
    // read data
    // ------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            bus_rdata <= 8'h00;
        end else if (bus_rd) begin
            if (flag_sel) begin
                bus_rdata <= {5'h00, irq_flag_reg};
            end else begin
                case (bus_addr)
                    TCB_OFF_MASK:   bus_rdata <= {5'h00, irq_mask_reg};
                    TCB_OFF_CTRL_A: bus_rdata <= ctrl_a_reg;
                    TCB_OFF_CTRL_B: bus_rdata <= {4'h0, wave_mode_hi_bit_reg, clk_select_reg};
                    TCB_OFF_COUNT:  bus_rdata <= count_value_reg;
                    TCB_OFF_CMP_A:  bus_rdata <= compare_a_value_reg;
                    TCB_OFF_CMP_B:  bus_rdata <= compare_b_value_reg;
                    default:        bus_rdata <= 8'h00;
                endcase
            end
        end
    end

endmodule

// >>> test/tcb_timer_sva.sv
// checker: port-level timing properties of the timer block
`timescale 1ns/10ps
module tcb_timer_sva
    import tcb_pkg::*;
(
    input wire logic       sys_clk,
    input wire logic       rst_n,
    input wire logic [7:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic       bus_wr,
    input wire logic       bus_rd,
    input wire logic [7:0] bus_rdata,
    input wire logic       global_irq_en,
    input wire logic       vec_ack_cmp_a,
    input wire logic       vec_ack_ovf,
    input wire logic       irq_cmp_a,
    input wire logic       irq_cmp_b,
    input wire logic       irq_ovf
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    property p_gate_a; irq_cmp_a |-> global_irq_en; endproperty
    a_gate_a: assert property (p_gate_a) else $error("irq a without global enable");
    property p_gate_b; irq_cmp_b |-> global_irq_en; endproperty
    a_gate_b: assert property (p_gate_b) else $error("irq b without global enable");
    property p_gate_ovf; irq_ovf |-> global_irq_en; endproperty
    a_gate_ovf: assert property (p_gate_ovf) else $error("irq ovf without global enable");
    property p_vec_a; vec_ack_cmp_a |=> !irq_cmp_a; endproperty
    a_vec_a: assert property (p_vec_a) else $error("vector did not clear a");
    property p_vec_ovf; vec_ack_ovf |=> !irq_ovf; endproperty
    a_vec_ovf: assert property (p_vec_ovf) else $error("vector did not clear ovf");
    property p_w1c; bus_wr && bus_addr == TCB_OFF_FLAGS && bus_wdata[TCB_BIT_CMP_A] |=> !irq_cmp_a; endproperty
    a_w1c: assert property (p_w1c) else $error("write one did not clear a");
    property p_alias;
        bus_wr && bus_addr == TCB_OFF_FLAGS - TCB_IO_SPACE_DELTA && bus_wdata[TCB_BIT_OVF] |=> !irq_ovf;
    endproperty
    a_alias: assert property (p_alias) else $error("alias write did not clear ovf");
    property p_force_rd; bus_rd && bus_addr == TCB_OFF_CTRL_B |=> bus_rdata[7:6] == 2'b00; endproperty
    a_force_rd: assert property (p_force_rd) else $error("force bits read nonzero");
    property p_force_quiet;
        bus_wr && bus_addr == TCB_OFF_CTRL_B && bus_wdata[7:6] != 2'b00 && bus_wdata[2:0] == 3'h0
            && !irq_cmp_a && !irq_cmp_b |=> (!irq_cmp_a && !irq_cmp_b)[*2];
    endproperty
    a_force_quiet: assert property (p_force_quiet) else $error("forced compare raised irq");
endmodule
bind tcb_timer tcb_timer_sva i_sva(.sys_clk, .rst_n, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata,
    .global_irq_en, .vec_ack_cmp_a, .vec_ack_ovf, .irq_cmp_a, .irq_cmp_b, .irq_ovf);

// >>> test/tcb_core_model.sv
// partner: core side that executes interrupt vectors
`timescale 1ns/10ps
module tcb_core_model (
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       irq_cmp_a,
    input  wire logic       irq_cmp_b,
    input  wire logic       irq_ovf,
    input  wire logic       auto_ack,
    input  wire logic [3:0] ack_wait,
    output logic            vec_ack_cmp_a,
    output logic            vec_ack_cmp_b,
    output logic            vec_ack_ovf
);
    logic [3:0] wait_cnt;
    logic       pending;
    assign pending = auto_ack && (irq_cmp_a || irq_cmp_b || irq_ovf) &&
                     !vec_ack_cmp_a && !vec_ack_cmp_b && !vec_ack_ovf;
    always @(negedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_cnt <= 4'h0;
            {vec_ack_cmp_a, vec_ack_cmp_b, vec_ack_ovf} <= 3'h0;
        end else if (pending && wait_cnt >= ack_wait) begin
            wait_cnt      <= 4'h0;
            vec_ack_cmp_a <= irq_cmp_a;
            vec_ack_cmp_b <= !irq_cmp_a && irq_cmp_b;
            vec_ack_ovf   <= !irq_cmp_a && !irq_cmp_b && irq_ovf;
        end else begin
            wait_cnt <= pending ? wait_cnt + 4'h1 : 4'h0;
            {vec_ack_cmp_a, vec_ack_cmp_b, vec_ack_ovf} <= 3'h0;
        end
    end
endmodule

// >>> test/tcb_timer_bench.sv
// testbench: register-level tests of the timer block
`timescale 1ns/10ps
module tcb_timer_bench
    import tcb_pkg::*;
;
    logic       sys_clk = 1'b0;
    logic       rst_n = 1'b0;
    logic [7:0] bus_addr = 8'h00;
    logic [7:0] bus_wdata = 8'h00;
    logic [7:0] bus_rdata;
    logic [7:0] rdv;
    logic       bus_wr = 1'b0;
    logic       bus_rd = 1'b0;
    logic       global_irq_en = 1'b0;
    logic       auto_ack = 1'b0;
    logic       vec_ack_cmp_a, vec_ack_cmp_b, vec_ack_ovf;
    logic       irq_cmp_a, irq_cmp_b, irq_ovf, wave_out_a, wave_out_b;
    int         err_total = 0;
    int         samples_checked = 0;
    int         div_tab [7] = '{1, TCB_DIV_8, TCB_DIV_32, TCB_DIV_64, TCB_DIV_128, TCB_DIV_256, TCB_DIV_1024};
    logic [7:0] rst_addr [8];

    always #10 sys_clk = ~sys_clk;

    tcb_timer i_dut(.sys_clk, .rst_n, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .global_irq_en,
        .vec_ack_cmp_a, .vec_ack_cmp_b, .vec_ack_ovf, .irq_cmp_a, .irq_cmp_b, .irq_ovf, .wave_out_a, .wave_out_b);
    tcb_core_model i_core(.sys_clk, .rst_n, .irq_cmp_a, .irq_cmp_b, .irq_ovf, .auto_ack, .ack_wait(4'h2),
        .vec_ack_cmp_a, .vec_ack_cmp_b, .vec_ack_ovf);

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus_addr = a;
        bus_wdata = d;
        bus_wr = 1'b1;
        @(negedge sys_clk);
        bus_wr = 1'b0;
        @(negedge sys_clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        bus_addr = a;
        bus_rd = 1'b1;
        @(negedge sys_clk);
        bus_rd = 1'b0;
        @(negedge sys_clk);
        d = bus_rdata;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_rng(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
        samples_checked++;
        if ($isunknown(got) || !(got >= lo && got <= hi)) begin
            err_total++;
            $display("mismatch at %0t: count %h outside %h..%h", $time, got, lo, hi);
        end
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
        rd(a, rdv);
        chk(rdv, exp);
    endtask
    task automatic run(input logic [7:0] start, input int n);
        wr(TCB_OFF_COUNT, start);
        wr(TCB_OFF_CTRL_B, 8'h01);
        repeat (n) @(negedge sys_clk);
        wr(TCB_OFF_CTRL_B, 8'h00);
    endtask
    task automatic summarize();
        $display("checked %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge sys_clk);
        err_total++;
        $display("mismatch at %0t: timeout", $time);
        summarize();
    end

    initial begin
        rst_addr = '{TCB_OFF_FLAGS, TCB_OFF_FLAGS - TCB_IO_SPACE_DELTA, TCB_OFF_MASK, TCB_OFF_CTRL_B,
                     TCB_OFF_COUNT, TCB_OFF_CMP_A, TCB_OFF_CMP_B, 8'h00};
        repeat (12) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        foreach (rst_addr[i]) chk_rd(rst_addr[i], TCB_RESET_VAL);
        $display("test reset values done");
        global_irq_en = 1'b1;
        wr(TCB_OFF_CMP_A, 8'h5a);
        wr(TCB_OFF_CMP_B, 8'ha5);
        wr(TCB_OFF_MASK, 8'hff);
        wr(TCB_OFF_CTRL_B, 8'hc8);
        chk_rd(TCB_OFF_CMP_A, 8'h5a);
        chk_rd(TCB_OFF_CMP_B, 8'ha5);
        chk_rd(TCB_OFF_MASK, TCB_MASK_RD);
        chk_rd(TCB_OFF_CTRL_B, 8'h08);
        wr(TCB_OFF_CTRL_B, 8'h00);
        $display("test register access done");
        wr(TCB_OFF_CTRL_A, 8'h50);
        wr(TCB_OFF_CTRL_B, 8'h80);
        chk({6'h0, wave_out_b, wave_out_a}, 8'h01);
        wr(TCB_OFF_CTRL_B, 8'h40);
        chk({6'h0, wave_out_b, wave_out_a}, 8'h03);
        chk_rd(TCB_OFF_FLAGS, 8'h00);
        wr(TCB_OFF_CTRL_A, 8'h51);
        wr(TCB_OFF_CTRL_B, 8'hc0);
        chk({6'h0, wave_out_b, wave_out_a}, 8'h03);
        wr(TCB_OFF_CTRL_B, 8'h00);
        chk({6'h0, wave_out_b, wave_out_a}, 8'h03);
        wr(TCB_OFF_CTRL_A, 8'h00);
        $display("test forced compare done");
        for (int cs = 1; cs < 8; cs++) begin
            wr(TCB_OFF_COUNT, 8'h00);
            wr(TCB_OFF_CTRL_B, 8'(cs));
            repeat (4 * div_tab[cs - 1]) @(negedge sys_clk);
            wr(TCB_OFF_CTRL_B, 8'h00);
            rd(TCB_OFF_COUNT, rdv);
            chk_rng(rdv, 8'h03, 8'h06);
        end
        wr(TCB_OFF_COUNT, 8'h77);
        repeat (50) @(negedge sys_clk);
        chk_rd(TCB_OFF_COUNT, 8'h77);
        $display("test prescaler done");
        run(8'h50, 200);
        chk_rd(TCB_OFF_FLAGS, 8'h07);
        chk({5'h0, irq_cmp_b, irq_cmp_a, irq_ovf}, 8'h07);
        wr(TCB_OFF_MASK, 8'h04);
        chk({5'h0, irq_cmp_b, irq_cmp_a, irq_ovf}, 8'h04);
        global_irq_en = 1'b0;
        chk_rd(TCB_OFF_FLAGS, 8'h07);
        chk({5'h0, irq_cmp_b, irq_cmp_a, irq_ovf}, 8'h00);
        global_irq_en = 1'b1;
        wr(TCB_OFF_MASK, 8'h07);
        auto_ack = 1'b1;
        repeat (30) @(negedge sys_clk);
        chk_rd(TCB_OFF_FLAGS, 8'h00);
        auto_ack = 1'b0;
        $display("test interrupts done");
        run(8'h50, 200);
        wr(TCB_OFF_FLAGS, 8'h00);
        chk_rd(TCB_OFF_FLAGS, 8'h07);
        wr(TCB_OFF_FLAGS - TCB_IO_SPACE_DELTA, 8'h01);
        chk_rd(TCB_OFF_FLAGS - TCB_IO_SPACE_DELTA, 8'h06);
        wr(TCB_OFF_FLAGS, 8'h06);
        chk_rd(TCB_OFF_FLAGS, 8'h00);
        wr(TCB_OFF_CTRL_B, 8'h01);
        wr(TCB_OFF_COUNT, 8'h5a);
        repeat (3) @(negedge sys_clk);
        wr(TCB_OFF_CTRL_B, 8'h00);
        chk_rd(TCB_OFF_FLAGS, 8'h00);
        $display("test flag clearing done");
        wr(TCB_OFF_CTRL_A, 8'h42);
        wr(TCB_OFF_CMP_A, 8'h10);
        run(8'h00, 90);
        chk_rd(TCB_OFF_COUNT, 8'h07);
        chk_rd(TCB_OFF_FLAGS, 8'h02);
        chk({6'h0, wave_out_b, wave_out_a}, 8'h02);
        wr(TCB_OFF_FLAGS, 8'h02);
        wr(TCB_OFF_CTRL_B, 8'h80);
        chk({6'h0, wave_out_b, wave_out_a}, 8'h03);
        chk_rd(TCB_OFF_COUNT, 8'h07);
        chk_rd(TCB_OFF_FLAGS, 8'h00);
        wr(TCB_OFF_CTRL_A, 8'h00);
        $display("test clear on compare done");
        summarize();
    end
endmodule
